/* pkg/bcu_pkg.sv */
package bcu_pkg;
	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_BKPT_ADDR0 = 8'h00;
	localparam logic [7:0] ADDR_BKPT_ADDR1 = 8'h04;
	localparam logic [7:0] ADDR_BKPT_ADDR2 = 8'h08;
	localparam logic [7:0] ADDR_BKPT_ADDR3 = 8'h0C;
	localparam logic [7:0] ADDR_CONTROL = 8'h1C;
	localparam logic [7:0] ADDR_HIT_STATUS = 8'h18;
	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_ENABLE_LSB = 0;
	localparam int CTL_EXACT_LOCAL = 8;
	localparam int CTL_EXACT_GLOBAL = 9;
	localparam int CTL_GUARD = 13;
	localparam int CTL_QUAL_LSB = 16;
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTL_WMASK = 32'hFFFF_23FF;
	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [1:0] LEN_BYTE = 2'h0;
	localparam logic [1:0] LEN_WORD = 2'h1;
	localparam logic [1:0] LEN_DWORD = 2'h3;
	localparam logic [1:0] QUAL_EXEC = 2'h0;
	localparam logic [1:0] QUAL_WRITE = 2'h1;
	localparam logic [1:0] QUAL_RDWR = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam int NUM_BKPT = 4;

	// Processor access presented for checking
	typedef struct packed {
		logic valid;
		logic isFetch;
		logic isWrite;
		logic [31:0] linAddr;
		logic [2:0] size; // Bytes accessed, 1..4
	} bcu_access_s;

	// Exception request to the core
	typedef struct packed {
		logic fault;
		logic trap;
		logic guardFault;
		logic [3:0] hits;
	} bcu_excp_s;
endpackage

/* rtl/bcu_breakpoint_control_unit.sv */
module bcu_breakpoint_control_unit (
	input wire logic core_clk,
	input wire logic resetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Processor side
	input wire logic realMode,
	input wire logic privLevel0,
	input wire logic taskSwitch,
	input wire logic handlerEntry,
	input wire bcu_pkg::bcu_access_s access,
	output bcu_pkg::bcu_excp_s excp,
	output logic waitOperands
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [31:0] bkptAddr [bcu_pkg::NUM_BKPT];
	logic [31:0] next_bkptAddr [bcu_pkg::NUM_BKPT];
	logic [31:0] control, next_control;
	logic [3:0] hitStatus, next_hitStatus;
	logic [7:0] awAddr, next_awAddr;
	logic awHeld, next_awHeld;
	logic [31:0] wData, next_wData;
	logic [3:0] wStrb, next_wStrb;
	logic wHeld, next_wHeld;
	logic bValid, next_bValid;
	logic [1:0] bResp, next_bResp;
	logic rValid, next_rValid;
	logic [31:0] rData, next_rData;
	logic [1:0] rResp, next_rResp;
	logic [3:0] match;
	logic [3:0] enabled;
	logic anyFault, anyTrap, guardHit, privOk;
	bcu_pkg::bcu_excp_s next_excp;

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Address decode to breakpoint index; 4 means not an address register
	function automatic logic [2:0] addrIndex(input logic [7:0] a);
		case (a)
			bcu_pkg::ADDR_BKPT_ADDR0: addrIndex = 3'h0;
			bcu_pkg::ADDR_BKPT_ADDR1: addrIndex = 3'h1;
			bcu_pkg::ADDR_BKPT_ADDR2: addrIndex = 3'h2;
			bcu_pkg::ADDR_BKPT_ADDR3: addrIndex = 3'h3;
			default: addrIndex = 3'h4;
		endcase
	endfunction

	// ----------------------------------------
	// Comparators
	// ----------------------------------------
	// privilege check on access
	assign privOk = realMode | privLevel0;

	genvar gi;
	generate
		for (gi = 0; gi < bcu_pkg::NUM_BKPT; gi++) begin : g_cmp
			logic [1:0] len, qual;
			logic [31:0] mask, lo, hi, accLo, accHi;
			logic hit;
			assign len = control[bcu_pkg::CTL_QUAL_LSB + 4*gi + 2 +: 2];
			assign qual = control[bcu_pkg::CTL_QUAL_LSB + 4*gi +: 2];
			assign mask = (len == bcu_pkg::LEN_DWORD) ? 32'hFFFF_FFFC :
				(len == bcu_pkg::LEN_WORD) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
			assign lo = bkptAddr[gi] & mask;
			assign hi = lo | ~mask;
			assign accLo = access.linAddr;
			// Last byte touched; size runs 1..4
			assign accHi = access.linAddr + {29'h0000_0000, access.size} - 32'h0000_0001;
			always_comb begin
				hit = 1'b0;
				if (access.valid) begin
					case (qual)
						bcu_pkg::QUAL_EXEC: hit = access.isFetch && (accLo == bkptAddr[gi]);
						// write only; overlap
						// Overlap means both byte ranges share at least one byte
						bcu_pkg::QUAL_WRITE: hit = !access.isFetch && access.isWrite &&
							(accLo <= hi) && (accHi >= lo);
						bcu_pkg::QUAL_RDWR: hit = !access.isFetch &&
							(accLo <= hi) && (accHi >= lo);
						default: hit = 1'b0;
					endcase
				end
			end
			// One result bit per comparator slot
			assign match[gi] = hit;
			assign enabled[gi] = control[2*gi] | control[2*gi + 1];
		end
	endgenerate

	// fault for execute, trap for data
	assign anyFault = |(match & enabled) && access.isFetch;
	assign anyTrap = |(match & enabled) && !access.isFetch;
	// stall while exact match selected; fetches stall too
	assign waitOperands = control[bcu_pkg::CTL_EXACT_LOCAL] | control[bcu_pkg::CTL_EXACT_GLOBAL];

	// ----------------------------------------
	// Bus and control next state
	// ----------------------------------------
	always_comb begin
		logic doWrite, doRead;
		logic [2:0] idx;
		doWrite = 1'b0;
		doRead = 1'b0;
		idx = 3'h0;
		next_bkptAddr = bkptAddr;
		next_control = control;
		next_hitStatus = hitStatus;
		next_awAddr = awAddr;
		next_awHeld = awHeld;
		next_wData = wData;
		next_wStrb = wStrb;
		next_wHeld = wHeld;
		next_bValid = bValid;
		next_bResp = bResp;
		next_rValid = rValid;
		next_rData = rData;
		next_rResp = rResp;
		guardHit = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awAddr = s_axi_awaddr;
			next_awHeld = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
			next_wHeld = 1'b1;
		end
		if (bValid && s_axi_bready) begin
			next_bValid = 1'b0;
		end
		if (rValid && s_axi_rready) begin
			next_rValid = 1'b0;
		end
		doWrite = awHeld && wHeld && !bValid;
		doRead = s_axi_arvalid && s_axi_arready;
		// guarded access faults instead of completing
		guardHit = (doWrite || doRead) && control[bcu_pkg::CTL_GUARD];
		// Hit status latches comparator results while any enabled hit occurs
		if (|(match & enabled)) begin
			next_hitStatus = hitStatus | match;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bValid = 1'b1;
			idx = addrIndex(awAddr);
			if (!privOk || guardHit) begin
				next_bResp = bcu_pkg::RESP_SLVERR;
			end else if (idx != 3'h4) begin
				next_bkptAddr[idx[1:0]] = merge(bkptAddr[idx[1:0]], wData, wStrb);
				next_bResp = bcu_pkg::RESP_OKAY;
			end else if (awAddr == bcu_pkg::ADDR_CONTROL) begin
				next_control = merge(control, wData, wStrb) & bcu_pkg::CTL_WMASK;
				next_bResp = bcu_pkg::RESP_OKAY;
			end else if (awAddr == bcu_pkg::ADDR_HIT_STATUS) begin
				// Clear wins only for bits with no new hit this cycle
				next_hitStatus = (hitStatus & ~wData[3:0]) | (match & {4{|(match & enabled)}});
				next_bResp = bcu_pkg::RESP_OKAY;
			end else begin
				next_bResp = bcu_pkg::RESP_DECERR;
			end
		end
		if (doRead) begin
			next_rValid = 1'b1;
			next_rData = 32'h0000_0000;
			next_rResp = bcu_pkg::RESP_OKAY;
			idx = addrIndex(s_axi_araddr);
			if (!privOk || guardHit) begin
				next_rResp = bcu_pkg::RESP_SLVERR;
			end else if (idx != 3'h4) begin
				next_rData = bkptAddr[idx[1:0]];
			end else if (s_axi_araddr == bcu_pkg::ADDR_CONTROL) begin
				next_rData = control;
			end else if (s_axi_araddr == bcu_pkg::ADDR_HIT_STATUS) begin
				next_rData = {28'h000_0000, hitStatus};
			end else begin
				next_rResp = bcu_pkg::RESP_DECERR;
			end
		end
		if (handlerEntry) begin
			next_control[bcu_pkg::CTL_GUARD] = 1'b0;
		end
		if (taskSwitch) begin
			next_control[bcu_pkg::CTL_EXACT_LOCAL] = 1'b0;
			for (int i = 0; i < bcu_pkg::NUM_BKPT; i++) begin
				next_control[2*i] = 1'b0;
			end
		end
		next_excp.fault = anyFault;
		next_excp.trap = anyTrap;
		next_excp.guardFault = guardHit;
		next_excp.hits = match;
	end

	// Handshake and answer outputs straight from holding state
	assign s_axi_awready = !awHeld;
	assign s_axi_wready = !wHeld;
	assign s_axi_arready = !rValid;
	assign s_axi_bvalid = bValid;
	assign s_axi_bresp = bResp;
	assign s_axi_rvalid = rValid;
	assign s_axi_rdata = rData;
	assign s_axi_rresp = rResp;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// reset disables all breakpoints
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < bcu_pkg::NUM_BKPT; i++) begin
				bkptAddr[i] <= 32'h0000_0000;
			end
			control <= bcu_pkg::CTL_RESET;
			hitStatus <= 4'h0;
			awAddr <= 8'h00;
			awHeld <= 1'b0;
			wData <= 32'h0000_0000;
			wStrb <= 4'h0;
			wHeld <= 1'b0;
			bValid <= 1'b0;
			bResp <= 2'h0;
			rValid <= 1'b0;
			rData <= 32'h0000_0000;
			rResp <= 2'h0;
			excp <= '0;
		end else begin
			bkptAddr <= next_bkptAddr;
			control <= next_control;
			hitStatus <= next_hitStatus;
			awAddr <= next_awAddr;
			awHeld <= next_awHeld;
			wData <= next_wData;
			wStrb <= next_wStrb;
			wHeld <= next_wHeld;
			bValid <= next_bValid;
			bResp <= next_bResp;
			rValid <= next_rValid;
			rData <= next_rData;
			rResp <= next_rResp;
			excp <= next_excp;
		end
	end
endmodule // bcu_breakpoint_control_unit

/* dv/bcu_checker_asserts.sv */
module bcu_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic realMode,
	input wire logic privLevel0,
	input wire bcu_pkg::bcu_access_s access,
	input wire bcu_pkg::bcu_excp_s excp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	// ----------------------------------------
	// Exception and bus checks
	// ----------------------------------------
	a_quiet_reset: assert property ($rose(resetn) |-> excp == 7'h00)
		else $error("exception output set after reset");
	a_fault_fetch: assert property (excp.fault |-> $past(access.valid && access.isFetch))
		else $error("fault without a fetch");
	a_trap_data: assert property (excp.trap |-> $past(access.valid && !access.isFetch))
		else $error("trap without a data access");
	a_hit_cause: assert property (excp.fault || excp.trap |-> excp.hits != 4'h0)
		else $error("exception without a hit");
	a_idle_quiet: assert property (!access.valid |=> excp.hits == 4'h0 && !excp.trap)
		else $error("hit reported without an access");
	a_fault_alone: assert property (excp.fault |-> !excp.trap)
		else $error("fault and trap together");
	a_priv_refuse: assert property (s_axi_arvalid && s_axi_arready && !(realMode || privLevel0)
		|=> s_axi_rvalid && s_axi_rresp == bcu_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unprivileged read not refused");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
		else $error("write response missing");
	// Main scenarios reached
	c_fault: cover property (excp.fault);
	c_trap: cover property (excp.trap);
	c_guard: cover property (excp.guardFault);
endmodule // bcu_checker

bind bcu_breakpoint_control_unit bcu_checker i_chk (.core_clk, .resetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .realMode, .privLevel0,
	.access, .excp);

/* dv/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, resetn, realMode, privLevel0, taskSwitch, handlerEntry, waitOperands;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	bcu_pkg::bcu_access_s access;
	bcu_pkg::bcu_excp_s excp;
	int n_fail;
	int compares;
	logic seenGuard;
	bcu_breakpoint_control_unit i_dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .realMode, .privLevel0,
		.taskSwitch, .handlerEntry, .access, .excp, .waitOperands);
	// ----------------------------------------
	// Clock, compare and verdict
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("Compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One register access; on a read d is the expected data
	task automatic bus(input logic wrt, input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic [2:0] rdy;
		logic [34:0] ans;
		@(posedge core_clk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wrt, wrt, !wrt};
		{s_axi_bready, s_axi_rready} <= 2'h3;
		repeat (20) begin
			@(negedge core_clk);
			rdy = {s_axi_awready, s_axi_wready, s_axi_arready};
			ans = wrt ? {s_axi_bvalid, s_axi_bresp, d} : {s_axi_rvalid, s_axi_rresp, s_axi_rdata};
			seenGuard = excp.guardFault;
			@(posedge core_clk);
			{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid, s_axi_wvalid,
				s_axi_arvalid} & ~rdy;
			if (ans[34]) begin
				{s_axi_bready, s_axi_rready} <= 2'h0;
				chk("resp", 32'(ans[33:32]), 32'(er));
				chk("rdata", ans[31:0], d);
				return;
			end
		end
		chk("response wait", 32'h0, 32'h1);
		report_and_stop();
	endtask
	// One processor access, exception word judged a cycle later
	task automatic acc(input logic f, input logic w, input logic [31:0] a, input logic [2:0] s,
		input logic [6:0] ex);
		@(posedge core_clk);
		access <= '{1'b1, f, w, a, s};
		@(posedge core_clk);
		access.valid <= 1'b0;
		@(negedge core_clk);
		chk("excp", 32'(excp), 32'(ex));
	endtask
	task automatic pulse(input logic ts);
		@(posedge core_clk);
		{taskSwitch, handlerEntry} <= {ts, !ts};
		@(posedge core_clk);
		{taskSwitch, handlerEntry} <= 2'h0;
		@(negedge core_clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_exec();
		bus(1'b0, bcu_pkg::ADDR_CONTROL, 32'h0000_0000, 2'h0);
		bus(1'b1, bcu_pkg::ADDR_BKPT_ADDR0, 32'h0000_0100, 2'h0);
		acc(1'b1, 1'b0, 32'h0000_0100, 3'h1, 7'h01);
		bus(1'b1, bcu_pkg::ADDR_CONTROL, 32'h0000_0002, 2'h0);
		acc(1'b1, 1'b0, 32'h0000_0100, 3'h1, 7'h41);
		acc(1'b1, 1'b0, 32'h0000_0101, 3'h1, 7'h00);
		acc(1'b0, 1'b0, 32'h0000_0100, 3'h1, 7'h00);
		$display("exec test done");
	endtask
	task automatic t_data();
		bus(1'b1, bcu_pkg::ADDR_BKPT_ADDR1, 32'h0000_0205, 2'h0);
		// exact global set with data breakpoints
		for (int l = 0; l < 4; l++) begin
			if (l == 2) continue;
			bus(1'b1, bcu_pkg::ADDR_CONTROL, {8'h0, l[1:0], 2'h3, 20'h0_0204}, 2'h0);
			acc(1'b0, 1'b0, 32'h0000_0204, 3'h1, (l != 0) ? 7'h22 : 7'h00);
			acc(1'b0, 1'b0, 32'h0000_0206, 3'h1, (l == 3) ? 7'h22 : 7'h00);
		end
		for (int q = 1; q < 4; q += 2) begin
			bus(1'b1, bcu_pkg::ADDR_CONTROL, {8'h0, 2'h3, q[1:0], 20'h0_0204}, 2'h0);
			acc(1'b0, 1'b0, 32'h0000_0203, 3'h2, (q == 3) ? 7'h22 : 7'h00);
			acc(1'b0, 1'b1, 32'h0000_0207, 3'h4, 7'h22);
			acc(1'b0, 1'b1, 32'h0000_0202, 3'h2, 7'h00);
		end
		bus(1'b1, bcu_pkg::ADDR_BKPT_ADDR0, 32'h0000_0300, 2'h0);
		bus(1'b1, bcu_pkg::ADDR_BKPT_ADDR1, 32'h0000_0302, 2'h0);
		bus(1'b1, bcu_pkg::ADDR_CONTROL, 32'h00FF_000A, 2'h0);
		acc(1'b0, 1'b1, 32'h0000_0301, 3'h1, 7'h23);
		bus(1'b0, bcu_pkg::ADDR_HIT_STATUS, 32'h0000_0003, 2'h0);
		bus(1'b1, bcu_pkg::ADDR_HIT_STATUS, 32'h0000_000F, 2'h0);
		bus(1'b0, bcu_pkg::ADDR_HIT_STATUS, 32'h0000_0000, 2'h0);
		$display("data test done");
	endtask
	task automatic t_task();
		bus(1'b1, bcu_pkg::ADDR_CONTROL, 32'h0000_035F, 2'h0);
		pulse(1'b1);
		bus(1'b0, bcu_pkg::ADDR_CONTROL, 32'h0000_020A, 2'h0);
		chk("waitOperands", 32'(waitOperands), 32'h1);
		bus(1'b1, bcu_pkg::ADDR_CONTROL, 32'h0000_0100, 2'h0);
		chk("waitOperands", 32'(waitOperands), 32'h1);
		pulse(1'b1);
		chk("waitOperands", 32'(waitOperands), 32'h0);
		$display("task switch test done");
	endtask
	task automatic t_guard();
		bus(1'b1, bcu_pkg::ADDR_CONTROL, 32'h0000_2000, 2'h0);
		bus(1'b0, bcu_pkg::ADDR_CONTROL, 32'h0000_0000, bcu_pkg::RESP_SLVERR);
		chk("guardFault", 32'(seenGuard), 32'h1);
		pulse(1'b0);
		bus(1'b0, bcu_pkg::ADDR_CONTROL, 32'h0000_0000, 2'h0);
		chk("guardFault", 32'(seenGuard), 32'h0);
		privLevel0 <= 1'b0;
		bus(1'b1, bcu_pkg::ADDR_BKPT_ADDR2, 32'h0000_0055, bcu_pkg::RESP_SLVERR);
		bus(1'b0, bcu_pkg::ADDR_BKPT_ADDR2, 32'h0000_0000, bcu_pkg::RESP_SLVERR);
		realMode <= 1'b1;
		bus(1'b0, bcu_pkg::ADDR_BKPT_ADDR2, 32'h0000_0000, 2'h0);
		bus(1'b0, 8'h40, 32'h0000_0000, bcu_pkg::RESP_DECERR);
		$display("guard test done");
	endtask
	// Reset, then the scenarios in turn
	initial begin
		{resetn, realMode, taskSwitch, handlerEntry, s_axi_bready, s_axi_rready} = 6'h00;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, privLevel0, s_axi_wstrb} = 8'h1F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		access = '0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		t_exec();
		t_data();
		t_task();
		t_guard();
		report_and_stop();
	end
endmodule // testbench
